// File: shared/pwm_bank_pkg.sv
// Types shared by the pwm bank modules
package pwm_bank_pkg;

    typedef enum logic [2:0] {
        base_rate_1mhz   = 3'h0,
        base_rate_100khz = 3'h1,
        base_rate_10khz  = 3'h2,
        base_rate_1khz   = 3'h3,
        base_rate_100hz  = 3'h4
    } base_sel_type;

    typedef enum logic {
        order_high_low = 1'b0,
        order_low_high = 1'b1
    } order_type;

    typedef enum logic [1:0] {
        chan_disarmed = 2'b01,
        chan_running  = 2'b10
    } chan_state_type;

    typedef struct packed {
        base_sel_type base_sel;
        order_type    order;
        logic         idle_level;
        logic         arm_en;
        logic         arm;
        logic [15:0]  period;
    } chan_cfg_type;

endpackage : pwm_bank_pkg

// File: shared/pwm_bank_regs.svh
// Register offsets, field positions, reset values and rate counts of the pwm bank
`ifndef PWM_BANK_REGS_SVH
`define PWM_BANK_REGS_SVH

`define NUM_CHANNELS        10
`define COUNT_WIDTH         16
`define DUTY_WIDTH          17
`define DUTY_ONE            17'h10000

`define CLK_HZ              125000000
`define RATE_1MHZ_HZ        1000000
`define DIV_1MHZ            (`CLK_HZ / `RATE_1MHZ_HZ)
`define DIV_DECADE          10
`define NUM_BASE_RATES      5
`define MIN_PERIOD          16'h0002

`define OFS_CONTROL         12'h000
`define OFS_SAMPLE          12'h004
`define OFS_STATUS          12'h008
`define OFS_CHAN_BASE       12'h100
`define CHAN_STRIDE_SHIFT   4
`define OFS_CHAN_CFG        4'h0
`define OFS_CHAN_PERIOD     4'h4
`define OFS_CHAN_DUTY       4'h8
`define OFS_CHAN_COUNT      4'hc

`define CTRL_RUN_BIT        0
`define CFG_BASE_LSB        0
`define CFG_ORDER_BIT       4
`define CFG_IDLE_BIT        5
`define CFG_ARM_EN_BIT      6
`define CFG_ARM_BIT         7
`define STATUS_ARMED_LSB    0
`define STATUS_LEVEL_LSB    16

`define RST_SAMPLE          16'h03e8
`define RST_PERIOD          16'h0064
`define RST_DUTY            17'h08000

`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// File: src/base_rate_gen.sv
// Divider chain making the five base rate enable pulses
`timescale 1ns/100ps
`include "pwm_bank_regs.svh"
module base_rate_gen
    import pwm_bank_pkg::*;
(
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // One-cycle enables, index 0 is the fastest
    output logic [`NUM_BASE_RATES-1:0]       rate_tick
);
    logic [7:0] pre_cnt_ff;
    logic       tick_1mhz_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_ff   <= 8'h00;
            tick_1mhz_ff <= 1'b0;
        end else if (pre_cnt_ff == 8'(`DIV_1MHZ - 1)) begin
            pre_cnt_ff   <= 8'h00;
            tick_1mhz_ff <= 1'b1;
        end else begin
            pre_cnt_ff   <= pre_cnt_ff + 8'h01;
            tick_1mhz_ff <= 1'b0;
        end
    end

    assign rate_tick[0] = tick_1mhz_ff;

    // Each decade stage counts ticks of the stage above
    genvar i;
    generate
        for (i = 1; i < `NUM_BASE_RATES; i++) begin : g_decade
            logic [3:0] dec_cnt_ff;
            logic       dec_tick_ff;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    dec_cnt_ff  <= 4'h0;
                    dec_tick_ff <= 1'b0;
                end else begin
                    dec_tick_ff <= 1'b0;
                    if (rate_tick[i-1]) begin
                        if (dec_cnt_ff == 4'(`DIV_DECADE - 1)) begin
                            dec_cnt_ff  <= 4'h0;
                            dec_tick_ff <= 1'b1;
                        end else begin
                            dec_cnt_ff <= dec_cnt_ff + 4'h1;
                        end
                    end
                end
            end
            assign rate_tick[i] = dec_tick_ff;
        end
    endgenerate
endmodule : base_rate_gen

// File: src/pwm_bank.sv
// Ten-channel pwm bank with an AXI4-Lite register slave
//
// Functional notes
// - Ten independent channels, one output each
// - Every channel counter is 16 bits
// - Five selectable base rates per channel
// - Output rate is base times factor below one
// - Duty input from zero to one, period fixed
// - High-low order starts period with high part
// - Low-high order starts period with low part
// - Duty sets high part length in either order
// - Disarmed while not running, armed when running
// - Disarmed output holds configured static level
// - Duty registered once per sample period
// - Optional arm input controls arming while running
// - Arm bit one arms, zero keeps disarmed
`timescale 1ns/100ps
`include "pwm_bank_regs.svh"
module pwm_bank
    import pwm_bank_pkg::*;
(
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite write address
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [11:0]                s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    // AXI4-Lite write response
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output logic [1:0]                      s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    input  wire logic [11:0]                s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    // AXI4-Lite read data
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    // Pulse outputs
    output logic [`NUM_CHANNELS-1:0]        pwm_out
);
    localparam int NCH = `NUM_CHANNELS;

    // Write channel state
    logic                        aw_held_ff;
    logic [11:0]                 aw_addr_ff;
    logic                        w_held_ff;
    logic [31:0]                 w_data_ff;
    logic [3:0]                  w_strb_ff;
    logic                        bvalid_ff;
    logic [1:0]                  bresp_ff;
    // Read channel state
    logic                        rvalid_ff;
    logic [31:0]                 rdata_ff;
    logic [1:0]                  rresp_ff;
    // Registers
    logic                        run_ff;
    logic [15:0]                 sample_ff;
    chan_cfg_type                cfg_ff [NCH];
    logic [`DUTY_WIDTH-1:0]      duty_shadow_ff [NCH];
    logic [`DUTY_WIDTH-1:0]      duty_active_ff [NCH];
    logic [15:0]                 sample_cnt_ff;
    logic [NCH-1:0]              pwm_out_ff;
    // Internal nets
    logic [`NUM_BASE_RATES-1:0]  rate_tick;
    logic [NCH-1:0]              chan_level;
    logic [NCH-1:0]              chan_armed;
    logic [15:0]                 chan_count [NCH];
    logic                        wr_fire;
    logic                        sample_tick;
    logic [31:0]                 nxt_rdata;
    logic [1:0]                  nxt_rresp;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    function automatic logic [31:0] cfg_word(input chan_cfg_type c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`CFG_BASE_LSB +: 3] = c.base_sel;
        w[`CFG_ORDER_BIT]     = c.order;
        w[`CFG_IDLE_BIT]      = c.idle_level;
        w[`CFG_ARM_EN_BIT]    = c.arm_en;
        w[`CFG_ARM_BIT]       = c.arm;
        return w;
    endfunction : cfg_word

    // Address and data may arrive in either order
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 12'h000;
        end else if (s_axi_awvalid && !aw_held_ff) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else if (s_axi_wvalid && !w_held_ff) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_ff <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready  = !w_held_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            if (aw_addr_ff[1:0] != 2'b00) begin
                bresp_ff <= `RESP_SLVERR;
            end else if (aw_addr_ff == `OFS_CONTROL || aw_addr_ff == `OFS_SAMPLE ||
                         aw_addr_ff == `OFS_STATUS) begin
                bresp_ff <= `RESP_OKAY;
            end else if (aw_addr_ff >= `OFS_CHAN_BASE &&
                         aw_addr_ff < `OFS_CHAN_BASE + 12'(NCH << `CHAN_STRIDE_SHIFT)) begin
                bresp_ff <= `RESP_OKAY;
            end else begin
                bresp_ff <= `RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // Global registers; status is read-only and ignores writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_ff    <= 1'b0;
            sample_ff <= `RST_SAMPLE;
        end else if (wr_fire && aw_addr_ff == `OFS_CONTROL && w_strb_ff[0]) begin
            run_ff <= w_data_ff[`CTRL_RUN_BIT];
        end else if (wr_fire && aw_addr_ff == `OFS_SAMPLE) begin
            sample_ff <= merge_strb({16'h0000, sample_ff}, w_data_ff, w_strb_ff)
                         [15:0];
        end
    end

    // Per-channel configuration and duty shadow
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_regs
            localparam logic [11:0] BASE = `OFS_CHAN_BASE + 12'(c << `CHAN_STRIDE_SHIFT);
            logic [31:0] cfg_new;
            assign cfg_new = merge_strb(cfg_word(cfg_ff[c]), w_data_ff, w_strb_ff);

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cfg_ff[c].base_sel   <= base_rate_1mhz;
                    cfg_ff[c].order      <= order_high_low;
                    cfg_ff[c].idle_level <= 1'b0;
                    cfg_ff[c].arm_en     <= 1'b0;
                    cfg_ff[c].arm        <= 1'b0;
                    cfg_ff[c].period     <= `RST_PERIOD;
                end else if (wr_fire && aw_addr_ff == BASE + 12'(`OFS_CHAN_CFG)) begin
                    // Undefined rate codes fall back to the fastest base
                    if (cfg_new[`CFG_BASE_LSB +: 3] > base_rate_100hz) begin
                        cfg_ff[c].base_sel <= base_rate_1mhz;
                    end else begin
                        cfg_ff[c].base_sel <= base_sel_type'(cfg_new[`CFG_BASE_LSB +: 3]);
                    end
                    cfg_ff[c].order      <= order_type'(cfg_new[`CFG_ORDER_BIT]);
                    cfg_ff[c].idle_level <= cfg_new[`CFG_IDLE_BIT];
                    cfg_ff[c].arm_en     <= cfg_new[`CFG_ARM_EN_BIT];
                    cfg_ff[c].arm        <= cfg_new[`CFG_ARM_BIT];
                end else if (wr_fire && aw_addr_ff == BASE + 12'(`OFS_CHAN_PERIOD)) begin
                    cfg_ff[c].period <= merge_strb({16'h0000, cfg_ff[c].period},
                                                   w_data_ff, w_strb_ff)[15:0];
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    duty_shadow_ff[c] <= `RST_DUTY;
                end else if (wr_fire && aw_addr_ff == BASE + 12'(`OFS_CHAN_DUTY)) begin
                    duty_shadow_ff[c] <= merge_strb({15'h0000, duty_shadow_ff[c]},
                                                    w_data_ff, w_strb_ff)[16:0];
                end
            end

            // Shadow moves to the channel only on the sample tick
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    duty_active_ff[c] <= `RST_DUTY;
                end else if (sample_tick) begin
                    duty_active_ff[c] <= duty_shadow_ff[c];
                end
            end

            // Not running forces disarm; arm bit rules only when enabled
            assign chan_armed[c] = run_ff && (!cfg_ff[c].arm_en || cfg_ff[c].arm);

            pwm_channel u_chan (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .rate_tick (rate_tick[cfg_ff[c].base_sel]),
                .armed     (chan_armed[c]),
                .cfg       (cfg_ff[c]),
                .duty      (duty_active_ff[c]),
                .level     (chan_level[c]),
                .count     (chan_count[c])
            );
        end
    endgenerate

    // Sample period counted in 1 MHz ticks; zero means every tick
    assign sample_tick = rate_tick[0] && (sample_cnt_ff + 16'h0001 >= sample_ff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_cnt_ff <= 16'h0000;
        end else if (sample_tick) begin
            sample_cnt_ff <= 16'h0000;
        end else if (rate_tick[0]) begin
            sample_cnt_ff <= sample_cnt_ff + 16'h0001;
        end
    end

    base_rate_gen u_rates (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .rate_tick (rate_tick)
    );

    // Output stage keeps pins straight off flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_out_ff <= '0;
        end else begin
            pwm_out_ff <= chan_level;
        end
    end

    assign pwm_out = pwm_out_ff;

    // Read decode
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = `RESP_OKAY;
        if (s_axi_araddr[1:0] != 2'b00) begin
            nxt_rresp = `RESP_SLVERR;
        end else if (s_axi_araddr == `OFS_CONTROL) begin
            nxt_rdata[`CTRL_RUN_BIT] = run_ff;
        end else if (s_axi_araddr == `OFS_SAMPLE) begin
            nxt_rdata[15:0] = sample_ff;
        end else if (s_axi_araddr == `OFS_STATUS) begin
            nxt_rdata[`STATUS_ARMED_LSB +: NCH] = chan_armed;
            nxt_rdata[`STATUS_LEVEL_LSB +: NCH] = chan_level;
        end else if (s_axi_araddr >= `OFS_CHAN_BASE &&
                     s_axi_araddr < `OFS_CHAN_BASE + 12'(NCH << `CHAN_STRIDE_SHIFT)) begin
            for (int k = 0; k < NCH; k++) begin
                if (s_axi_araddr[11:4] == 8'((`OFS_CHAN_BASE >> 4) + k)) begin
                    case (s_axi_araddr[3:0])
                        `OFS_CHAN_CFG:    nxt_rdata = cfg_word(cfg_ff[k]);
                        `OFS_CHAN_PERIOD: nxt_rdata[15:0] = cfg_ff[k].period;
                        `OFS_CHAN_DUTY:   nxt_rdata[16:0] = duty_shadow_ff[k];
                        `OFS_CHAN_COUNT:  nxt_rdata[15:0] = chan_count[k];
                        default:          nxt_rresp = `RESP_SLVERR;
                    endcase
                end
            end
        end else begin
            nxt_rresp = `RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
endmodule : pwm_bank

// File: src/pwm_channel.sv
// One 16-bit pwm counter channel
`timescale 1ns/100ps
`include "pwm_bank_regs.svh"
module pwm_channel
    import pwm_bank_pkg::*;
(
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // Control
    input  wire logic                     rate_tick,
    input  wire logic                     armed,
    input  wire chan_cfg_type             cfg,
    input  wire logic [`DUTY_WIDTH-1:0]   duty,
    // State
    output logic                          level,
    output logic [`COUNT_WIDTH-1:0]       count
);
    chan_state_type          state_ff;
    logic [15:0]             cnt_ff;
    logic [15:0]             per_ff;
    logic [15:0]             high_ff;
    logic                    level_ff;
    logic [15:0]             new_per;
    logic [32:0]             prod;
    logic [15:0]             new_high;
    logic [15:0]             nxt_cnt;
    logic [15:0]             use_per;
    logic [15:0]             use_high;

    // Period below two counts would make the factor reach one
    assign new_per  = (cfg.period < `MIN_PERIOD) ? `MIN_PERIOD : cfg.period;
    assign prod     = 33'(new_per) * 33'(duty);
    assign new_high = duty[16] ? new_per : prod[31:16];
    assign nxt_cnt  = (state_ff != chan_running || cnt_ff >= per_ff - 16'h0001)
                      ? 16'h0000 : cnt_ff + 16'h0001;
    // Fresh duty and period only at a period boundary
    assign use_per  = (nxt_cnt == 16'h0000) ? new_per : per_ff;
    assign use_high = (nxt_cnt == 16'h0000) ? new_high : high_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= chan_disarmed;
            cnt_ff   <= 16'h0000;
            per_ff   <= `MIN_PERIOD;
            high_ff  <= 16'h0000;
            level_ff <= 1'b0;
        end else begin
            case (state_ff)
                chan_disarmed: begin
                    level_ff <= cfg.idle_level;
                    cnt_ff   <= 16'h0000;
                    if (armed) begin
                        state_ff <= chan_running;
                        per_ff   <= new_per;
                        high_ff  <= new_high;
                        if (cfg.order == order_high_low) begin
                            level_ff <= (new_high != 16'h0000);
                        end else begin
                            level_ff <= (new_high == new_per);
                        end
                    end
                end
                chan_running: begin
                    if (!armed) begin
                        state_ff <= chan_disarmed;
                        level_ff <= cfg.idle_level;
                    end else if (rate_tick) begin
                        cnt_ff  <= nxt_cnt;
                        per_ff  <= use_per;
                        high_ff <= use_high;
                        if (cfg.order == order_high_low) begin
                            level_ff <= (nxt_cnt < use_high);
                        end else begin
                            level_ff <= (nxt_cnt >= use_per - use_high);
                        end
                    end
                end
                default: begin
                    state_ff <= chan_disarmed;
                end
            endcase
        end
    end

    assign level = level_ff;
    assign count = cnt_ff;
endmodule : pwm_channel

// File: verification/host_model.sv
// Host processor model issuing register cycles to the pwm bank
`timescale 1ns/100ps
module host_model
    import pwm_bank_pkg::*;
(
    // Clock
    input wire logic        aclk,
    // Write side
    output logic            s_axi_awvalid,
    input wire logic        s_axi_awready,
    output logic [11:0]     s_axi_awaddr,
    output logic            s_axi_wvalid,
    input wire logic        s_axi_wready,
    output logic [31:0]     s_axi_wdata,
    input wire logic        s_axi_bvalid,
    output logic            s_axi_bready,
    // Read side
    output logic            s_axi_arvalid,
    input wire logic        s_axi_arready,
    output logic [11:0]     s_axi_araddr,
    input wire logic        s_axi_rvalid,
    output logic            s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp
);
    // Ready held high, so no release can collide with a new request
    assign s_axi_bready = 1'b1;
    assign s_axi_rready = 1'b1;
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    end
    // Callers keep duty within 0..1 and period above one
    task wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        do @(posedge aclk); while (!s_axi_bvalid);
    endtask : wr
    task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
endmodule : host_model

// File: verification/pwm_bank_asserts.sv
// Bus handshake and response checks for the pwm bank
`timescale 1ns/100ps
`include "pwm_bank_regs.svh"
module pwm_bank_asserts
    import pwm_bank_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write side
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read side
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Pulse outputs
    input wire logic [9:0]  pwm_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_done: assert property (p_b_done) else $error("bvalid kept");
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("rvalid kept");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("arready while rvalid");
    property p_aw_block;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("awready not dropped");
    property p_w_block;
        s_axi_wvalid && s_axi_wready |=> !s_axi_wready;
    endproperty
    a_w_block: assert property (p_w_block) else $error("wready not dropped");
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
    c_rise: cover property ($rose(pwm_out[0]));
endmodule : pwm_bank_asserts

bind pwm_bank pwm_bank_asserts u_chk (.*);

// File: verification/test_pwm_bank.sv
// Self-checking bench for the pwm bank
`timescale 1ns/100ps
`include "pwm_bank_regs.svh"
`define CHK(g, e) chk(g, e)
module test_pwm_bank
    import pwm_bank_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] pwm_out;
    int bad_count = 0, n_checks = 0, hi, lo;
    always #4 aclk = ~aclk;
    pwm_bank u_dut (.*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hf), .s_axi_arprot(3'h0));
    host_model u_host (.*);
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    function logic [11:0] ca(input int k, input logic [3:0] o);
        return `OFS_CHAN_BASE + 12'(k << `CHAN_STRIDE_SHIFT) + 12'(o);
    endfunction : ca
    task cw(input int k, input logic [31:0] c, input logic [31:0] p, input logic [31:0] d);
        u_host.wr(ca(k, `OFS_CHAN_CFG), c);
        u_host.wr(ca(k, `OFS_CHAN_PERIOD), p);
        u_host.wr(ca(k, `OFS_CHAN_DUTY), d);
    endtask : cw
    // Rising edge to rising edge, so a part period at start is skipped
    task meas(input int k);
        hi = 0;
        lo = 0;
        while (pwm_out[k] !== 1'b0) @(posedge aclk);
        while (pwm_out[k] !== 1'b1) @(posedge aclk);
        while (pwm_out[k] === 1'b1) begin hi++; @(posedge aclk); end
        while (pwm_out[k] === 1'b0) begin lo++; @(posedge aclk); end
    endtask : meas
    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        u_host.rd(`OFS_SAMPLE, d, r);
        `CHK(d, `RST_SAMPLE);
        u_host.rd(ca(0, `OFS_CHAN_DUTY), d, r);
        `CHK(d, `RST_DUTY);
        u_host.rd(12'hffc, d, r);
        `CHK(r, `RESP_SLVERR);
    endtask : t_regs
    task t_idle;
        u_host.wr(`OFS_SAMPLE, 32'h1);
        cw(0, 32'h00, 32'h4, 32'h4000);
        cw(1, 32'h10, 32'h4, 32'h4000);
        cw(2, 32'h00, 32'h64, 32'h10000);
        cw(3, 32'h20, 32'h64, 32'h8000);
        cw(4, 32'h20, 32'h64, 32'h0);
        cw(5, 32'h60, 32'h64, 32'h0);
        cw(6, 32'h01, 32'h2, 32'h8000);
        repeat (300) @(posedge aclk);
        `CHK(pwm_out, 10'h038);
    endtask : t_idle
    task t_order;
        u_host.wr(`OFS_CONTROL, 32'h1);
        repeat (4) @(posedge aclk);
        `CHK(pwm_out[1:0], 2'b01);
        `CHK(pwm_out[5], 1'b1);
    endtask : t_order
    task t_width;
        repeat (2) meas(0);
        `CHK(hi, `DIV_1MHZ);
        `CHK(lo, 3 * `DIV_1MHZ);
        meas(1);
        `CHK(hi, `DIV_1MHZ);
        `CHK(lo, 3 * `DIV_1MHZ);
        meas(6);
        `CHK(hi, `DIV_1MHZ * `DIV_DECADE);
        `CHK({pwm_out[4], pwm_out[2]}, 2'b01);
        u_host.wr(ca(0, `OFS_CHAN_DUTY), 32'hc000);
        repeat (3) meas(0);
        `CHK(hi, 3 * `DIV_1MHZ);
        `CHK(lo, `DIV_1MHZ);
    endtask : t_width
    task t_arm;
        u_host.wr(ca(5, `OFS_CHAN_CFG), 32'he0);
        repeat (4) @(posedge aclk);
        `CHK(pwm_out[5], 1'b0);
        u_host.wr(ca(5, `OFS_CHAN_CFG), 32'h60);
        repeat (4) @(posedge aclk);
        `CHK(pwm_out[5], 1'b1);
    endtask : t_arm
    task t_stop;
        u_host.wr(`OFS_CONTROL, 32'h0);
        repeat (4) @(posedge aclk);
        `CHK(pwm_out, 10'h038);
    endtask : t_stop
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_idle;
        t_order;
        t_width;
        t_arm;
        t_stop;
        stop_test;
    end
    initial begin
        repeat (60000) @(posedge aclk);
        bad_count++;
        stop_test;
    end
endmodule : test_pwm_bank
